// file: jti_tap.sv
// test access port with id/user code, chip port bridge and reset sequencing
`timescale 1ns/10ps
// What this block does
// - one standard boundary-scan port that scans the i/o pins
// - instruction register 4 bits, data register path 32 bits
// - outer port reaches inner chip port, which loads and debugs the tile
// - tms high for five tck cycles returns port to reset state
// - identification instruction shifts out 32-bit version, part and maker value
// - user-code instruction shifts customer id, unused span, silicon revision
// - customer id copied from security bits 22..31, zero when unprogrammed
// - global reset active low, acts at once, resets whole device
// - after reset release wait for multiplier lock, then boot in chosen mode
// - all port operations are synchronous to tck
// - security bit 0 disables the port's access to tile state
// - security bit 13 blocks port access to one-time memory
module jti_tap #(
	parameter logic [3:0] ID_VERSION = 4'h0,
	parameter logic [15:0] ID_PART = 16'h1234,
	parameter logic [10:0] ID_MAKER = 11'h155,
	parameter logic [11:0] SILICON_REV = 12'h001,
	parameter int PIN_W = 8
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	input wire logic [31:0] security_word,
	input wire logic security_valid,
	input wire logic pll_locked,
	output logic boot_start,
	output logic boot_from_otp,
	output logic dev_rst_n,
	input wire logic [PIN_W-1:0] pin_in,
	output logic [PIN_W-1:0] pin_out,
	output logic pin_test_mode,
	output logic chip_capture,
	output logic chip_shift,
	output logic chip_update,
	output logic chip_tdi,
	input wire logic chip_tdo,
	output logic otp_access_en
);
	// reset crossing into tck domain: asynchronous assert, tck-synchronised release
	logic [1:0] trst_sync_r;
	logic trst_n;
	always_ff @(posedge tck or negedge arst_n) begin
		if (!arst_n) trst_sync_r <= 2'b00;
		else trst_sync_r <= {trst_sync_r[0], 1'b1};
	end
	assign trst_n = trst_sync_r[1];

	// security word crosses as a quasi-static level once loaded
	logic [1:0] sec_ok_sync_r;
	logic [31:0] sec_tck_r;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) sec_ok_sync_r <= 2'b00;
		else sec_ok_sync_r <= {sec_ok_sync_r[0], security_valid};
	end
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) sec_tck_r <= 32'h00000000;
		else if (sec_ok_sync_r[1]) sec_tck_r <= security_word;
	end
	// the flag rises on the same edge as the first load so the word is never read stale
	logic sec_ld_r;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) sec_ld_r <= 1'b0;
		else sec_ld_r <= sec_ok_sync_r[1];
	end
	// until the word is loaded the port stays locked, the safe default
	logic port_off;
	assign port_off = !sec_ld_r ||
		sec_tck_r[jti_pkg::SEC_JTAG_OFF];
	assign otp_access_en = !port_off &&
		!sec_tck_r[jti_pkg::SEC_OTP_OFF];

	jti_pkg::jti_tap_t st_r;
	jti_pkg::jti_tap_t st_nxt;
	logic [2:0] tms_hi_r;
	always_comb begin
		unique case (st_r)
		jti_pkg::TS_RESET: st_nxt = tms ? jti_pkg::TS_RESET : jti_pkg::TS_IDLE;
		jti_pkg::TS_IDLE: st_nxt = tms ? jti_pkg::TS_SEL_DR : jti_pkg::TS_IDLE;
		jti_pkg::TS_SEL_DR: st_nxt = tms ? jti_pkg::TS_SEL_IR : jti_pkg::TS_CAP_DR;
		jti_pkg::TS_CAP_DR: st_nxt = tms ? jti_pkg::TS_EX1_DR : jti_pkg::TS_SH_DR;
		jti_pkg::TS_SH_DR: st_nxt = tms ? jti_pkg::TS_EX1_DR : jti_pkg::TS_SH_DR;
		jti_pkg::TS_EX1_DR: st_nxt = tms ? jti_pkg::TS_UP_DR : jti_pkg::TS_PA_DR;
		jti_pkg::TS_PA_DR: st_nxt = tms ? jti_pkg::TS_EX2_DR : jti_pkg::TS_PA_DR;
		jti_pkg::TS_EX2_DR: st_nxt = tms ? jti_pkg::TS_UP_DR : jti_pkg::TS_SH_DR;
		jti_pkg::TS_UP_DR: st_nxt = tms ? jti_pkg::TS_SEL_DR : jti_pkg::TS_IDLE;
		jti_pkg::TS_SEL_IR: st_nxt = tms ? jti_pkg::TS_RESET : jti_pkg::TS_CAP_IR;
		jti_pkg::TS_CAP_IR: st_nxt = tms ? jti_pkg::TS_EX1_IR : jti_pkg::TS_SH_IR;
		jti_pkg::TS_SH_IR: st_nxt = tms ? jti_pkg::TS_EX1_IR : jti_pkg::TS_SH_IR;
		jti_pkg::TS_EX1_IR: st_nxt = tms ? jti_pkg::TS_UP_IR : jti_pkg::TS_PA_IR;
		jti_pkg::TS_PA_IR: st_nxt = tms ? jti_pkg::TS_EX2_IR : jti_pkg::TS_PA_IR;
		jti_pkg::TS_EX2_IR: st_nxt = tms ? jti_pkg::TS_UP_IR : jti_pkg::TS_SH_IR;
		jti_pkg::TS_UP_IR: st_nxt = tms ? jti_pkg::TS_SEL_DR : jti_pkg::TS_IDLE;
		endcase
	end
	// explicit five-high counter backs up the state graph from any state
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) tms_hi_r <= 3'h0;
		else if (!tms) tms_hi_r <= 3'h0;
		else if (tms_hi_r != 3'(jti_pkg::RESET_TMS_CNT - 1))
			tms_hi_r <= tms_hi_r + 3'h1;
	end
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) st_r <= jti_pkg::TS_RESET;
		else if (tms && tms_hi_r == 3'(jti_pkg::RESET_TMS_CNT - 1))
			st_r <= jti_pkg::TS_RESET;
		else st_r <= st_nxt;
	end

	logic [jti_pkg::IR_W-1:0] ir_sh_r;
	logic [jti_pkg::IR_W-1:0] ir_r;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) ir_sh_r <= '0;
		else if (st_r == jti_pkg::TS_CAP_IR) ir_sh_r <= jti_pkg::IR_CAPTURE;
		else if (st_r == jti_pkg::TS_SH_IR)
			ir_sh_r <= {tdi, ir_sh_r[jti_pkg::IR_W-1:1]};
	end
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) ir_r <= jti_pkg::IR_RESET;
		else if (st_r == jti_pkg::TS_RESET) ir_r <= jti_pkg::IR_RESET;
		else if (st_r == jti_pkg::TS_UP_IR) ir_r <= ir_sh_r;
	end

	logic [31:0] id_val;
	logic [31:0] uc_val;
	logic [jti_pkg::CUST_W-1:0] customer_id_field;
	assign id_val = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
	// unprogrammed memory reads as zeros, so the field follows it directly
	assign customer_id_field =
		sec_tck_r[jti_pkg::SEC_CUST_LSB +: jti_pkg::CUST_W];
	assign uc_val = {customer_id_field,
		{(jti_pkg::UC_CUST_LSB - jti_pkg::UC_REV_W){1'b0}},
		SILICON_REV};

	// one-hot view of the current instruction; unknown codes mean bypass
	logic sel_id;
	logic sel_uc;
	logic sel_ext;
	logic sel_smp;
	logic sel_chp;
	always_comb begin
		sel_id = 1'b0;
		sel_uc = 1'b0;
		sel_ext = 1'b0;
		sel_smp = 1'b0;
		sel_chp = 1'b0;
		unique case (ir_r)
		jti_pkg::IR_DEVICE_IDENTIFICATION: sel_id = 1'b1;
		jti_pkg::IR_USERCODE: sel_uc = 1'b1;
		jti_pkg::IR_EXTEST: sel_ext = 1'b1;
		jti_pkg::IR_SAMPLE: sel_smp = 1'b1;
		jti_pkg::IR_CHIP_DR: sel_chp = 1'b1;
		default: ;
		endcase
	end
	logic is_chip;
	logic is_bsr;
	assign is_chip = sel_chp && !port_off;
	assign is_bsr = sel_ext || sel_smp;

	// pins cross into tck domain through two flops before capture
	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	logic [jti_pkg::DR_W-1:0] dr_r;
	wire logic [PIN_W-1:0] bsr_q;
	wire logic [PIN_W-1:0] bsr_upd_q;
	logic byp_r;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) dr_r <= '0;
		else if (st_r == jti_pkg::TS_CAP_DR) begin
			if (ir_r == jti_pkg::IR_DEVICE_IDENTIFICATION) dr_r <= id_val;
			else if (ir_r == jti_pkg::IR_USERCODE) dr_r <= uc_val;
			else dr_r <= '0;
		end else if (st_r == jti_pkg::TS_SH_DR)
			dr_r <= {tdi, dr_r[jti_pkg::DR_W-1:1]};
	end
	// one capture/shift/update cell per pin; the chain empties towards bit 0
	for (genvar gi = 0; gi < PIN_W; gi++) begin : g_cell
		logic sh_in;
		logic cell_r;
		logic hold_r;
		if (gi == PIN_W - 1) begin : g_top
			assign sh_in = tdi;
		end else begin : g_mid
			assign sh_in = bsr_q[gi + 1];
		end
		always_ff @(posedge tck or negedge trst_n) begin
			if (!trst_n) cell_r <= 1'b0;
			else if (st_r == jti_pkg::TS_CAP_DR && is_bsr)
				cell_r <= pin_s2_r[gi];
			else if (st_r == jti_pkg::TS_SH_DR && is_bsr)
				cell_r <= sh_in;
		end
		// update latch keeps the pins steady while the chain shifts
		always_ff @(posedge tck or negedge trst_n) begin
			if (!trst_n) hold_r <= 1'b0;
			else if (st_r == jti_pkg::TS_UP_DR && is_bsr) hold_r <= cell_r;
		end
		assign bsr_q[gi] = cell_r;
		assign bsr_upd_q[gi] = hold_r;
	end
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) byp_r <= 1'b0;
		else if (st_r == jti_pkg::TS_CAP_DR) byp_r <= 1'b0;
		else if (st_r == jti_pkg::TS_SH_DR) byp_r <= tdi;
	end
	logic test_mode_r;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) test_mode_r <= 1'b0;
		else test_mode_r <= sel_ext;
	end
	assign pin_out = bsr_upd_q;
	assign pin_test_mode = test_mode_r;

	assign chip_capture = is_chip && st_r == jti_pkg::TS_CAP_DR;
	assign chip_shift = is_chip && st_r == jti_pkg::TS_SH_DR;
	assign chip_update = is_chip && st_r == jti_pkg::TS_UP_DR;
	assign chip_tdi = is_chip ? tdi : 1'b0;

	// tdo changes on the falling edge, as the boundary-scan timing expects
	logic tdo_bit;
	always_comb begin
		tdo_bit = byp_r;
		if (st_r == jti_pkg::TS_SH_IR) tdo_bit = ir_sh_r[0];
		else if (ir_r == jti_pkg::IR_DEVICE_IDENTIFICATION || ir_r == jti_pkg::IR_USERCODE)
			tdo_bit = dr_r[0];
		else if (is_bsr) tdo_bit = bsr_q[0];
		else if (is_chip) tdo_bit = chip_tdo;
	end
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else begin
			tdo <= tdo_bit;
			tdo_oe_n <= !(st_r == jti_pkg::TS_SH_IR ||
				st_r == jti_pkg::TS_SH_DR);
		end
	end

	// system side: lock wait then boot; lock passes two flops
	logic [1:0] lock_sync_r;
	logic [1:0] sec_sys_sync_r;
	jti_pkg::jti_boot_t boot_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lock_sync_r <= 2'b00;
			sec_sys_sync_r <= 2'b00;
		end else if (clk_en) begin
			lock_sync_r <= {lock_sync_r[0], pll_locked};
			sec_sys_sync_r <= {sec_sys_sync_r[0], security_valid};
		end
	end
	// the word is quasi-static once valid; the mode bit is copied a cycle
	// after the flag settles so the boot decision never sees it moving
	logic mode_ld_r;
	logic mode_otp_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode_ld_r <= 1'b0;
			mode_otp_r <= 1'b0;
		end else if (clk_en) begin
			mode_ld_r <= sec_sys_sync_r[1];
			if (sec_sys_sync_r[1])
				mode_otp_r <= security_word[jti_pkg::BOOT_OTP_BIT];
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			boot_r <= jti_pkg::BS_RESET;
			boot_start <= 1'b0;
			boot_from_otp <= 1'b0;
			dev_rst_n <= 1'b0;
		end else if (clk_en) begin
			boot_start <= 1'b0;
			unique case (boot_r)
			jti_pkg::BS_RESET: begin
				dev_rst_n <= 1'b1;
				boot_r <= jti_pkg::BS_LOCK;
			end
			jti_pkg::BS_LOCK:
				if (lock_sync_r[1] && mode_ld_r) begin
					boot_start <= 1'b1;
					boot_from_otp <= mode_otp_r;
					boot_r <= jti_pkg::BS_RUN;
				end
			jti_pkg::BS_RUN: boot_r <= jti_pkg::BS_RUN;
			default: boot_r <= jti_pkg::BS_RESET;
			endcase
		end
	end
endmodule

// file: jti_pkg.sv
// package for the test access port block: constants and state encodings
package jti_pkg;
	localparam int IR_W = 4;
	localparam int DR_W = 32;
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_SAMPLE = 4'h1;
	localparam logic [3:0] IR_DEVICE_IDENTIFICATION = 4'h2;
	localparam logic [3:0] IR_USERCODE = 4'h3;
	localparam logic [3:0] IR_CHIP_DR = 4'h4;
	localparam logic [3:0] IR_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_RESET = IR_DEVICE_IDENTIFICATION;
	localparam int ID_VER_LSB = 28;
	localparam int ID_PART_LSB = 12;
	localparam int ID_MFR_LSB = 1;
	localparam int UC_CUST_LSB = 22;
	localparam int UC_REV_W = 12;
	localparam int SEC_JTAG_OFF = 0;
	localparam int SEC_OTP_OFF = 13;
	localparam int SEC_CUST_LSB = 22;
	localparam int CUST_W = 10;
	localparam int RESET_TMS_CNT = 5;
	localparam real RST_MIN_NS = 100.0;
	localparam real CLK_NS = 5.0;
	localparam int RST_MIN_CYC = int'((RST_MIN_NS + CLK_NS - 0.001) / CLK_NS);
	localparam logic [3:0] BOOT_FLASH = 4'h0;
	localparam int BOOT_OTP_BIT = 5;
	typedef enum logic [3:0] {
		TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
		TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR = 4'h6, TS_EX2_DR = 4'h7,
		TS_UP_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SH_IR = 4'hB,
		TS_EX1_IR = 4'hC, TS_PA_IR = 4'hD, TS_EX2_IR = 4'hE, TS_UP_IR = 4'hF
	} jti_tap_t;
	typedef enum logic [1:0] {
		BS_RESET = 2'h0, BS_LOCK = 2'h1, BS_RUN = 2'h2
	} jti_boot_t;
endpackage

// file: jti_tap_asserts.sv
// checker for the test port block: boot order, gating and shift timing
`timescale 1ns/10ps
module jti_tap_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo_oe_n,
	input wire logic [31:0] security_word,
	input wire logic security_valid,
	input wire logic pll_locked,
	input wire logic boot_start,
	input wire logic boot_from_otp,
	input wire logic dev_rst_n,
	input wire logic chip_shift,
	input wire logic chip_update,
	input wire logic otp_access_en
);
	// tck-domain state settles a few edges after reset is released
	logic [2:0] tck_seen_r;
	always_ff @(posedge tck or negedge arst_n) begin
		if (!arst_n) tck_seen_r <= 3'h0;
		else if (tck_seen_r != 3'h7) tck_seen_r <= tck_seen_r + 3'h1;
	end
	sequence s_rel;
		$rose(arst_n);
	endsequence
	sequence s_dev_up;
		!dev_rst_n ##[1:2] dev_rst_n;
	endsequence
	a_dev_held: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_rel |-> s_dev_up) else $error("device reset release wrong");
	a_boot_late: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_rel |-> !boot_start [*3]) else $error("boot too early");
	a_boot_lock: assert property (@(posedge clk_sys) disable iff (!arst_n)
		boot_start |-> $past(pll_locked, 3) && $past(security_valid, 3))
		else $error("boot without lock");
	a_boot_once: assert property (@(posedge clk_sys) disable iff (!arst_n)
		boot_start |=> !boot_start) else $error("boot pulse too long");
	a_boot_mode: assert property (@(posedge clk_sys) disable iff (!arst_n)
		boot_start |-> ##[0:1] boot_from_otp == security_word[5])
		else $error("boot mode wrong");
	a_otp_gate: assert property (@(posedge tck) disable iff (!arst_n)
		tck_seen_r == 3'h7 |-> otp_access_en == ($past(security_valid, 3)
		&& !$past(security_word[0]) && !$past(security_word[13])))
		else $error("otp gate wrong");
	a_chip_lock: assert property (@(posedge tck) disable iff (!arst_n)
		(!security_valid || security_word[0]) |-> !chip_shift && !chip_update)
		else $error("chip port reached while locked");
	a_tap_reset: assert property (@(posedge tck) disable iff (!arst_n)
		tms [*5] |-> tdo_oe_n) else $error("port not reset by tms");
	a_oe_shift: assert property (@(posedge tck) disable iff (!arst_n)
		!tdo_oe_n |-> !$past(tms)) else $error("tdo enabled outside shift");
endmodule
bind jti_tap jti_tap_chk u_chk (.clk_sys, .arst_n, .tck, .tms, .tdo_oe_n,
	.security_word, .security_valid, .pll_locked, .boot_start, .boot_from_otp,
	.dev_rst_n, .chip_shift, .chip_update, .otp_access_en);

// file: jti_host.sv
// host model: walks the port state machine and shifts frames
`timescale 1ns/10ps
module jti_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// tck stands low between frames; inputs move only while it is low
	task automatic clk1(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#6 tck = 1'b1;
		o = tdo;
		#6 tck = 1'b0;
	endtask
	task automatic reset5();
		logic o;
		repeat (5) clk1(1'b1, 1'b0, o);
		clk1(1'b0, 1'b0, o);
	endtask
	task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
		output logic [31:0] q);
		logic o;
		q = '0;
		clk1(1'b1, 1'b0, o);
		if (is_ir)
			clk1(1'b1, 1'b0, o);
		clk1(1'b0, 1'b0, o);
		clk1(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			clk1(i == n - 1, din[i], o);
			q[i] = o;
		end
		clk1(1'b1, 1'b0, o);
		clk1(1'b0, 1'b0, o);
	endtask
endmodule

// file: jti_tap_tb.sv
// self-checking bench for the test port block
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module jti_tap_tb;
	// identity values are arbitrary
	localparam logic [3:0] VER = 4'h3;
	localparam logic [15:0] PART = 16'hA5C3;
	localparam logic [10:0] MAKER = 11'h2B7;
	localparam logic [11:0] REV = 12'h04E;
	localparam logic [31:0] ID = {VER, PART, MAKER, 1'b1};
	logic clk_sys = 1'b0, arst_n = 1'b0, pll_locked = 1'b0;
	logic security_valid = 1'b1, b;
	logic [31:0] security_word = 32'h0, q, w;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] pin_out;
	logic pin_test_mode;
	logic tck, tms, tdi, tdo, chip_shift, boot_start, boot_from_otp;
	logic dev_rst_n, otp_access_en;
	int seed = 32'h9071;
	int failures = 0, total_checks = 0, nshift = 0, nboot = 0, cyc = 0;
	jti_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
		.SILICON_REV(REV)) uut (.clk_sys, .arst_n, .clk_en(1'b1), .tck, .tms,
		.tdi, .tdo, .tdo_oe_n(), .security_word, .security_valid, .pll_locked,
		.boot_start, .boot_from_otp, .dev_rst_n, .pin_in, .pin_out,
		.pin_test_mode, .chip_capture(), .chip_shift, .chip_update(),
		.chip_tdi(), .chip_tdo(1'b1), .otp_access_en);
	jti_host host (.tck, .tms, .tdi, .tdo);
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge tck) if (chip_shift === 1'b1) nshift++;
	always @(posedge clk_sys) begin
		if (boot_start === 1'b1) nboot++;
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] exp_uc(input logic [31:0] s);
		return {s[31:22], 10'h000, REV};
	endfunction
	// reset lands off the edge so the async path is what gets seen
	task automatic boot_seq(input logic [31:0] v);
		@(posedge clk_sys);
		#1 arst_n = 1'b0;
		#1 `CHK("dev_rst_n", 0, dev_rst_n);
		security_word = v;
		security_valid = 1'b1;
		pll_locked = 1'b0;
		repeat (jti_pkg::RST_MIN_CYC) @(posedge clk_sys);
		arst_n <= 1'b1;
		nboot = 0;
		repeat (8) @(posedge clk_sys);
		`CHK("early boot", 0, nboot);
		pll_locked <= 1'b1;
		repeat (12) @(posedge clk_sys);
		`CHK("boot count", 1, nboot);
		`CHK("boot mode", v[5], boot_from_otp);
		$display("boot test done");
	endtask
	initial begin
		boot_seq($random(seed) & 32'hFFFF_DFFE);
		host.reset5();
		host.scan(1'b0, 32, $random(seed), q);
		`CHK("device_identification", ID, q);
		host.scan(1'b1, 4, jti_pkg::IR_USERCODE, q);
		`CHK("ir capture", jti_pkg::IR_CAPTURE, q[3:0]);
		for (int k = 0; k < 4; k++) begin
			w = (k == 0) ? 32'h0 : $random(seed) & 32'hFFFF_FFFE;
			@(posedge clk_sys);
			security_word <= w;
			pin_in <= $random(seed);
			repeat (4) @(posedge clk_sys);
			host.scan(1'b0, 32, $random(seed), q);
			`CHK("usercode", exp_uc(w), q);
			`CHK("otp gate", !w[13], otp_access_en);
		end
		$display("usercode test done");
		host.scan(1'b1, 4, jti_pkg::IR_EXTEST, q);
		host.scan(1'b0, 8, 32'h0000_005A, q);
		`CHK("pin capture", pin_in, q[7:0]);
		`CHK("pin update", 8'h5A, pin_out);
		`CHK("test mode", 1, pin_test_mode);
		$display("boundary test done");
		// abort a shift half way: five tms highs must restore the id path
		host.clk1(1'b1, 1'b0, b);
		repeat (3) host.clk1(1'b0, 1'b1, b);
		host.reset5();
		host.scan(1'b0, 32, 32'h0, q);
		`CHK("id after abort", ID, q);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			security_valid <= (k != 2);
			security_word <= {$random(seed)} & 32'hFFFF_DFFE | (k == 1);
			repeat (4) @(posedge clk_sys);
			host.scan(1'b1, 4, jti_pkg::IR_CHIP_DR, q);
			nshift = 0;
			host.scan(1'b0, 32, 32'h0, q);
			`CHK("chip shifts", (k == 0) ? 32 : 0, nshift);
			`CHK("chip data", (k == 0) ? 32'hFFFF_FFFF : 0, q);
			`CHK("otp lock", k == 0, otp_access_en);
		end
		$display("chip port test done");
		boot_seq($random(seed) | 32'h0000_0020);
		end_sim();
	end
endmodule
